/* File: rtl/bmsd_boot_select.sv */
`timescale 1ns/1ps
`default_nettype none
`include "bmsd_consts.svh"
module bmsd_boot_select (
	input wire logic CLK_I,
	input wire logic RST_B_I,
	input wire logic ROM_BOOT_SEL_A_I,
	input wire logic LINK_BOOT_SEL_A_I,
	input wire logic BOOT_MEM_SEL_A_I,
	output logic BOOT_MEM_SEL_A_O,
	output logic BOOT_MEM_SEL_A_OE_O,
	input wire logic ROM_BOOT_SEL_GROUP_I,
	input wire logic LINK_BOOT_SEL_GROUP_I,
	input wire logic BOOT_MEM_SEL_GROUP_I,
	output logic BOOT_MEM_SEL_GROUP_O,
	output logic BOOT_MEM_SEL_GROUP_OE_O,
	input wire logic BUS_OWNED_I,
	input wire logic [1:0] BUS_OWNER_I,
	input wire logic [3:0] BOOT_FETCH_I,
	output logic [2:0] BOOT_MODE_A_O,
	output logic [2:0] BOOT_MODE_B_O,
	output logic [2:0] BOOT_MODE_C_O,
	output logic [2:0] BOOT_MODE_D_O,
	output logic CYCLE_EN_O,
	input wire logic [3:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [3:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY
);
	logic rst_q1;
	logic rst_n;
	logic [2:0] strap_a;
	logic [2:0] strap_g;
	bmsd_pkg::bmsd_mode_t mode_a;
	bmsd_pkg::bmsd_mode_t mode_g;
	logic own_a;
	logic own_g;
	logic [1:0] ctrl;
	logic aw_held;
	logic w_held;
	logic [3:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic [31:0] status;
	logic [2:0] eff_a;
	logic [2:0] eff_g;
	logic cs_act_a;
	logic cs_act_g;
	logic wr_fire;
	logic aw_is_ctrl;
	logic aw_is_status;
	logic ar_is_ctrl;
	logic ar_is_status;
	logic [1:0] next_ctrl;
	logic [31:0] next_rdata;
	logic [1:0] next_rresp;
	logic [1:0] next_bresp;

	function automatic bmsd_pkg::bmsd_mode_t decode_mode(input logic [2:0] s);
		bmsd_pkg::bmsd_mode_t m;
		m = bmsd_pkg::BOOT_RSVD;
		unique case (s)
			3'h4: m = bmsd_pkg::BOOT_EPROM;
			3'h1: m = bmsd_pkg::BOOT_HOST;
			3'h3: m = bmsd_pkg::BOOT_LINK;
			3'h0: m = bmsd_pkg::BOOT_NONE;
			default: m = bmsd_pkg::BOOT_RSVD;
		endcase
		return m;
	endfunction : decode_mode

	// rom-boot 1 with link-boot 0 makes the pin an output, so its input level is dropped
	function automatic logic [2:0] fold_strap(input logic [2:0] s);
		logic [2:0] f;
		f = s;
		if (s[2:1] == 2'h2) begin
			f = 3'h4;
		end
		return f;
	endfunction : fold_strap

	// true when a byte address lands on the word of the given register
	function automatic logic reg_hit(input logic [3:0] addr, input logic [3:0] reg_addr);
		return addr[3:2] == reg_addr[3:2];
	endfunction : reg_hit

	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			rst_q1 <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_q1 <= 1'b1;
			rst_n <= rst_q1;
		end
	end

	// straps follow the pins while reset is held, then freeze
	always_ff @(posedge CLK_I) begin
		if (!rst_n) begin
			strap_a <= {ROM_BOOT_SEL_A_I, LINK_BOOT_SEL_A_I, BOOT_MEM_SEL_A_I};
			strap_g <= {ROM_BOOT_SEL_GROUP_I, LINK_BOOT_SEL_GROUP_I, BOOT_MEM_SEL_GROUP_I};
		end
	end

	// in EPROM mode the pin is an output, so its input level is ignored
	assign eff_a = fold_strap(strap_a);
	assign eff_g = fold_strap(strap_g);

	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			mode_a <= bmsd_pkg::BOOT_RSVD;
			mode_g <= bmsd_pkg::BOOT_RSVD;
		end else begin
			mode_a <= decode_mode(eff_a);
			mode_g <= decode_mode(eff_g);
		end
	end

	assign own_a = BUS_OWNED_I && (BUS_OWNER_I == `BMSD_OWNER_A);
	assign own_g = BUS_OWNED_I && (BUS_OWNER_I != `BMSD_OWNER_A);

	// a select asks for the part only while its processor fetches and boot is not released
	assign cs_act_a = BOOT_FETCH_I[0] && !ctrl[`BMSD_CT_DONE_A_BIT];
	assign cs_act_g = BOOT_FETCH_I[BUS_OWNER_I] && (BUS_OWNER_I != `BMSD_OWNER_A)
		&& !ctrl[`BMSD_CT_DONE_G_BIT];

	// chip select is active low; the driver is enabled only for the owner of the bus in EPROM mode, after reset
	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			BOOT_MEM_SEL_A_OE_O <= 1'b0;
			BOOT_MEM_SEL_A_O <= 1'b1;
			BOOT_MEM_SEL_GROUP_OE_O <= 1'b0;
			BOOT_MEM_SEL_GROUP_O <= 1'b1;
		end else begin
			BOOT_MEM_SEL_A_OE_O <= rst_n && (mode_a == bmsd_pkg::BOOT_EPROM) && own_a;
			BOOT_MEM_SEL_A_O <= !cs_act_a;
			BOOT_MEM_SEL_GROUP_OE_O <= rst_n && (mode_g == bmsd_pkg::BOOT_EPROM) && own_g;
			BOOT_MEM_SEL_GROUP_O <= !cs_act_g;
		end
	end

	assign BOOT_MODE_A_O = mode_a;
	assign BOOT_MODE_B_O = mode_g;
	assign BOOT_MODE_C_O = mode_g;
	assign BOOT_MODE_D_O = mode_g;

	// one instruction cycle per input clock
	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			CYCLE_EN_O <= 1'b0;
		end else begin
			CYCLE_EN_O <= rst_n;
		end
	end

	// address decode, shared by both paths
	assign aw_is_ctrl = reg_hit(aw_addr, `BMSD_CTRL_ADDR);
	assign aw_is_status = reg_hit(aw_addr, `BMSD_STATUS_ADDR);
	assign ar_is_ctrl = reg_hit(S_AXI_ARADDR, `BMSD_CTRL_ADDR);
	assign ar_is_status = reg_hit(S_AXI_ARADDR, `BMSD_STATUS_ADDR);

	// write path: address and data taken in either order
	// each channel holds its word until the pair is complete
	assign wr_fire = aw_held && w_held;
	assign S_AXI_AWREADY = !aw_held && !S_AXI_BVALID;
	assign S_AXI_WREADY = !w_held && !S_AXI_BVALID;

	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			aw_held <= 1'b0;
			aw_addr <= 4'h0;
		end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
			aw_held <= 1'b1;
			aw_addr <= S_AXI_AWADDR;
		end else if (aw_held && w_held) begin
			aw_held <= 1'b0;
		end
	end

	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			w_held <= 1'b0;
			w_data <= 32'h0;
			w_strb <= 4'h0;
		end else if (S_AXI_WVALID && S_AXI_WREADY) begin
			w_held <= 1'b1;
			w_data <= S_AXI_WDATA;
			w_strb <= S_AXI_WSTRB;
		end else if (aw_held && w_held) begin
			w_held <= 1'b0;
		end
	end

	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			ctrl <= `BMSD_CTRL_RESET;
		end else if (wr_fire) begin
			ctrl <= next_ctrl;
		end
	end

	// only the low byte lane carries the two stored bits; status writes are dropped
	always_comb begin
		next_ctrl = ctrl;
		if (aw_is_ctrl && w_strb[0]) begin
			next_ctrl = w_data[1:0];
		end
	end

	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= `BMSD_RESP_OKAY;
		end else if (aw_held && w_held) begin
			S_AXI_BVALID <= 1'b1;
			S_AXI_BRESP <= next_bresp;
		end else if (S_AXI_BREADY) begin
			S_AXI_BVALID <= 1'b0;
		end
	end

	// unmapped writes are answered but change nothing
	always_comb begin
		next_bresp = `BMSD_RESP_DECERR;
		if (aw_is_ctrl || aw_is_status) begin
			next_bresp = `BMSD_RESP_OKAY;
		end
	end

	// read path
	always_comb begin
		status = 32'h0;
		status[`BMSD_ST_MODE_A_LSB +: 3] = mode_a;
		status[`BMSD_ST_MODE_G_LSB +: 3] = mode_g;
		status[`BMSD_ST_RSVD_A_BIT] = (mode_a == bmsd_pkg::BOOT_RSVD);
		status[`BMSD_ST_RSVD_G_BIT] = (mode_g == bmsd_pkg::BOOT_RSVD);
		status[`BMSD_ST_OWN_A_BIT] = BOOT_MEM_SEL_A_OE_O;
		status[`BMSD_ST_OWN_G_BIT] = BOOT_MEM_SEL_GROUP_OE_O;
	end

	assign S_AXI_ARREADY = !S_AXI_RVALID;

	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= 32'h0;
			S_AXI_RRESP <= `BMSD_RESP_OKAY;
		end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
			S_AXI_RVALID <= 1'b1;
			S_AXI_RRESP <= next_rresp;
			S_AXI_RDATA <= next_rdata;
		end else if (S_AXI_RREADY) begin
			S_AXI_RVALID <= 1'b0;
		end
	end

	// unmapped reads return zero with a decode error
	always_comb begin
		next_rdata = 32'h0;
		next_rresp = `BMSD_RESP_DECERR;
		if (ar_is_status) begin
			next_rdata = status;
			next_rresp = `BMSD_RESP_OKAY;
		end else if (ar_is_ctrl) begin
			next_rdata = {30'h0, ctrl};
			next_rresp = `BMSD_RESP_OKAY;
		end
	end
endmodule : bmsd_boot_select
`default_nettype wire

/* File: rtl/bmsd_consts.svh */
`ifndef BMSD_CONSTS_SVH
`define BMSD_CONSTS_SVH
// register byte addresses
`define BMSD_STATUS_ADDR 4'h0
`define BMSD_CTRL_ADDR 4'h4
// status fields
`define BMSD_ST_MODE_A_LSB 0
`define BMSD_ST_MODE_G_LSB 4
`define BMSD_ST_RSVD_A_BIT 8
`define BMSD_ST_RSVD_G_BIT 9
`define BMSD_ST_OWN_A_BIT 10
`define BMSD_ST_OWN_G_BIT 11
// control fields
`define BMSD_CT_DONE_A_BIT 0
`define BMSD_CT_DONE_G_BIT 1
`define BMSD_CTRL_RESET 2'h0
// bus answers
`define BMSD_RESP_OKAY 2'h0
`define BMSD_RESP_DECERR 2'h3
// processor index of the bus owner
`define BMSD_OWNER_A 2'h0
`endif

/* File: rtl/bmsd_pkg.sv */
package bmsd_pkg;
	typedef enum logic [2:0] {
		BOOT_EPROM,
		BOOT_HOST,
		BOOT_LINK,
		BOOT_NONE,
		BOOT_RSVD
	} bmsd_mode_t;
endpackage : bmsd_pkg

/* File: bench/bmsd_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module bmsd_props (
	input wire logic CLK_I,
	input wire logic RST_B_I,
	input wire logic BOOT_MEM_SEL_A_O,
	input wire logic BOOT_MEM_SEL_A_OE_O,
	input wire logic BOOT_MEM_SEL_GROUP_OE_O,
	input wire logic BUS_OWNED_I,
	input wire logic [1:0] BUS_OWNER_I,
	input wire logic [3:0] BOOT_FETCH_I,
	input wire logic [2:0] BOOT_MODE_A_O,
	input wire logic [2:0] BOOT_MODE_B_O,
	input wire logic [2:0] BOOT_MODE_C_O,
	input wire logic [2:0] BOOT_MODE_D_O,
	input wire logic CYCLE_EN_O
);
	default clocking @(posedge CLK_I); endclocking
	default disable iff (!RST_B_I);
	AST_GRP_SAME: assert property (BOOT_MODE_B_O == BOOT_MODE_C_O && BOOT_MODE_C_O == BOOT_MODE_D_O)
		else $error("group modes differ");
	AST_A_OWNER: assert property ($rose(BOOT_MEM_SEL_A_OE_O) |-> $past(BUS_OWNED_I) && $past(BUS_OWNER_I) == 2'h0)
		else $error("a pin driven without ownership");
	AST_G_OWNER: assert property ($rose(BOOT_MEM_SEL_GROUP_OE_O) |-> $past(BUS_OWNED_I) && $past(BUS_OWNER_I) != 2'h0)
		else $error("group pin driven without ownership");
	AST_A_ROM: assert property (BOOT_MEM_SEL_A_OE_O |-> BOOT_MODE_A_O == 3'h0)
		else $error("a pin driven outside rom mode");
	AST_G_ROM: assert property (BOOT_MEM_SEL_GROUP_OE_O |-> BOOT_MODE_B_O == 3'h0)
		else $error("group pin driven outside rom mode");
	AST_CYC_RUN: assert property (CYCLE_EN_O |=> CYCLE_EN_O)
		else $error("cycle enable dropped");
	AST_MODE_HOLD: assert property (CYCLE_EN_O |=> $stable(BOOT_MODE_A_O) && $stable(BOOT_MODE_B_O))
		else $error("mode changed after reset");
	AST_CS_FETCH: assert property ($fell(BOOT_MEM_SEL_A_O) |-> $past(BOOT_FETCH_I[0]) && BOOT_MEM_SEL_A_OE_O)
		else $error("chip select without fetch");
endmodule : bmsd_props
bind bmsd_boot_select bmsd_props u_props (.*);
`default_nettype wire

/* File: bench/bmsd_rom_model.sv */
`timescale 1ns/1ps
`default_nettype none
module bmsd_rom_model (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic cs_b_i,
	output logic [7:0] data_o,
	output logic [7:0] reads_o
);
	// byte-wide part; released data bus toggles
	always @(posedge clk_i) begin
		if (!rst_b_i) begin
			reads_o <= 8'h00;
			data_o <= 8'h00;
		end else if (!cs_b_i) begin
			reads_o <= reads_o + 8'h01;
			data_o <= reads_o;
		end else
			data_o <= ~data_o;
	end
endmodule : bmsd_rom_model
`default_nettype wire

/* File: bench/boot_mode_select_decoder_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module boot_mode_select_decoder_tb;
	logic clk = 1'b0, rb = 1'b0, ra = 1'b0, la = 1'b0, ba = 1'b1, rg = 1'b0, lg = 1'b0, bg = 1'b1;
	logic own = 1'b0, awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
	logic [1:0] ownr = 2'h0;
	logic [3:0] fet = 4'h0, awa = 4'h0, ara = 4'h0;
	logic [31:0] wd = 32'h0;
	logic csa, oea, csg, oeg, cyc, awr, wrd, bv, arr, rv;
	logic [1:0] bresp, rresp;
	logic [31:0] rd;
	logic [2:0] ma, mb, mc, md;
	logic [7:0] rom_d, rom_n;
	int error_cnt = 0, cmp_count = 0;
	wire logic pa = oea ? csa : ba;
	wire logic pg = oeg ? csg : bg;
	always #2.5 clk = ~clk;
	bmsd_boot_select dut (.CLK_I(clk), .RST_B_I(rb), .ROM_BOOT_SEL_A_I(ra), .LINK_BOOT_SEL_A_I(la),
		.BOOT_MEM_SEL_A_I(pa), .BOOT_MEM_SEL_A_O(csa), .BOOT_MEM_SEL_A_OE_O(oea),
		.ROM_BOOT_SEL_GROUP_I(rg), .LINK_BOOT_SEL_GROUP_I(lg), .BOOT_MEM_SEL_GROUP_I(pg),
		.BOOT_MEM_SEL_GROUP_O(csg), .BOOT_MEM_SEL_GROUP_OE_O(oeg), .BUS_OWNED_I(own),
		.BUS_OWNER_I(ownr), .BOOT_FETCH_I(fet), .BOOT_MODE_A_O(ma), .BOOT_MODE_B_O(mb),
		.BOOT_MODE_C_O(mc), .BOOT_MODE_D_O(md), .CYCLE_EN_O(cyc), .S_AXI_AWADDR(awa),
		.S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF),
		.S_AXI_WVALID(wv), .S_AXI_WREADY(wrd), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv),
		.S_AXI_BREADY(br), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
		.S_AXI_RDATA(rd), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rr));
	bmsd_rom_model rom (.clk_i(clk), .rst_b_i(rb), .cs_b_i(pa), .data_o(rom_d), .reads_o(rom_n));
	task automatic end_of_test;
		$display("errors %0d compares %0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : end_of_test
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task automatic tmo(input int n);
		if (n >= 50) begin
			error_cnt++;
			end_of_test();
		end
	endtask : tmo
	task automatic rst(input logic [2:0] a, input logic [2:0] g);
		{ra, la, ba} <= a;
		{rg, lg, bg} <= g;
		rb <= 1'b0;
		repeat (3) @(posedge clk);
		rb <= 1'b1;
		repeat (4) @(posedge clk);
	endtask : rst
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		int n;
		logic ta, tw, tb;
		logic [1:0] rs;
		@(posedge clk);
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		br <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(negedge clk);
			ta = awr && awv;
			tw = wrd && wv;
			tb = bv;
			rs = bresp;
			@(posedge clk);
			if (ta) awv <= 1'b0;
			if (tw) wv <= 1'b0;
			if (tb) break;
		end
		br <= 1'b0;
		tmo(n);
		chk("bresp", 32'h0, 32'(rs));
	endtask : wr
	task automatic rdc(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er);
		int n;
		logic ta, tv;
		logic [31:0] dq;
		logic [1:0] rs;
		@(posedge clk);
		ara <= a;
		arv <= 1'b1;
		rr <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(negedge clk);
			ta = arr && arv;
			tv = rv;
			dq = rd;
			rs = rresp;
			@(posedge clk);
			if (ta) arv <= 1'b0;
			if (tv) break;
		end
		rr <= 1'b0;
		tmo(n);
		chk("rdata", e, dq);
		chk("rresp", 32'(er), 32'(rs));
	endtask : rdc
	task automatic t_modes;
		logic [2:0] st [6];
		logic [2:0] ex [6];
		st = '{3'h4, 3'h1, 3'h3, 3'h0, 3'h2, 3'h6};
		ex = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h4};
		for (int i = 0; i < 6; i++) begin
			rst(st[i], st[5 - i]);
			chk("mode_a", 32'(ex[i]), 32'(ma));
			chk("mode_b", 32'(ex[5 - i]), 32'(mb));
			chk("mode_c", 32'(ex[5 - i]), 32'(mc));
			chk("mode_d", 32'(ex[5 - i]), 32'(md));
			chk("cycle_en", 32'h1, 32'(cyc));
			{ra, la, ba} <= ~st[i];
			repeat (3) @(posedge clk);
			chk("mode_held", 32'(ex[i]), 32'(ma));
		end
	endtask : t_modes
	task automatic t_boot;
		rst(3'h5, 3'h5);
		own <= 1'b1;
		fet <= 4'h1;
		repeat (2) @(posedge clk);
		chk("oe_a", 32'h1, 32'(oea));
		chk("cs_a", 32'h0, 32'(pa));
		chk("oe_g", 32'h0, 32'(oeg));
		repeat (2) @(posedge clk);
		ownr <= 2'h1;
		fet <= 4'h2;
		repeat (2) @(posedge clk);
		chk("reads", 32'h4, 32'(rom_n));
		chk("oe_g", 32'h1, 32'(oeg));
		chk("cs_g", 32'h0, 32'(pg));
		rdc(4'h0, 32'h800, 2'h0);
		rdc(4'h4, 32'h0, 2'h0);
		wr(4'h4, 32'h3);
		repeat (2) @(posedge clk);
		chk("cs_g_done", 32'h1, 32'(pg));
		rdc(4'h4, 32'h3, 2'h0);
		rdc(4'h8, 32'h0, 2'h3);
	endtask : t_boot
	initial begin
		t_modes();
		t_boot();
		end_of_test();
	end
endmodule : boot_mode_select_decoder_tb
`default_nettype wire
